// >>> amp_protection_manager.sv
`timescale 1ns/1ps
// Overview of operation
// - Above 140 C lower gain step by step, keep playing.
// - Above 155 C disable the power stage at once.
// - Load impedance drop over 2 A: clamp current, keep playing.
// - Short over 2 A: switch off, hold disabled at least 100 ms.
// - After overcurrent shutdown hold diagnostic low for first 50 ms.
// - Persistent load short: retry once every 100 ms.
// - Rail short: stay disabled, no periodic retry, restart when gone.
// - Start-up from Sleep checks rail shorts before enabling stages.
// - Every restart after full shutdown runs the rail-short check first.
// - Supply below 10 V: shut down at once, diagnostic pin low.
// - Undervoltage cleared: wait 100 ms then restart.
// - Supply above 36 V: shut down; restart 100 ms after it clears.
// - Flag rail imbalance outside 8/5 to 8/3 of half-rail reference.
// - Symmetrical supply: release imbalance only within 6 % of start.
// - Diagnostic pin low for any protection except thermal gain reduction and current clamping.
// - Asymmetrical supply: enable half-rail buffers, switch after charge.
// - Symmetrical supply keeps both half-rail buffers disabled.
// - Wake low Sleep; wake high engage low Mute; both high Operating.
// - Mute: stages switch at 50 % duty, input converters disabled.
module amp_protection_manager
    import amp_protection_pkg::*;
#(
    parameter int TICK_COUNT = TICK_CYCLES
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wakeSelectInput,
    input wire logic engageInput,
    input wire protFlags_t protFlags,
    input wire logic faultIndicatorPinIn,
    output logic faultIndicatorPinOut,
    output logic faultIndicatorPinOe,
    output stageCtrl_t stageCtrl,
    output logic [GAIN_W-1:0] gainAtten
);

    // ****************************************
    // Input sampling and timebase
    // ****************************************
    protFlags_t flags_q;
    logic wake_q, engage_q;
    ampState_t state_q, state_d;
    logic [TICK_W-1:0] tickCnt_q;
    logic [MS_W-1:0] msCnt_q;
    logic tick, timerRestart, symSupply_q, ubActive_q;
    logic [CAUSE_W-1:0] cause_q, causeSet;
    logic extLow, supplyFault, active, retryDone, diagLow;
    stageCtrl_t stage_d;

    always_ff @(posedge clock)
    begin
        if (srst)
            {flags_q, wake_q, engage_q} <= '0;
        else
            {flags_q, wake_q, engage_q} <= {protFlags, wakeSelectInput, engageInput};
    end

    assign timerRestart = state_d != state_q;
    assign tick = tickCnt_q == TICK_W'(TICK_COUNT - 1);

    // Restart on every state change so each interval is exact
    always_ff @(posedge clock)
    begin
        if (srst || timerRestart || tick)
            tickCnt_q <= '0;
        else
            tickCnt_q <= tickCnt_q + 1'h1;
    end

    always_ff @(posedge clock)
    begin
        if (srst || timerRestart)
            msCnt_q <= '0;
        else if (tick && msCnt_q != MS_W'(RETRY_MS - 1))
            msCnt_q <= msCnt_q + 1'h1;
    end

    assign retryDone = tick && msCnt_q == MS_W'(RETRY_MS - 1);

    // ****************************************
    // Imbalance tracking
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (srst)
            ubActive_q <= 1'h0;
        else if (flags_q.unbalLow || flags_q.unbalHigh)
            ubActive_q <= 1'h1;
        else if (symSupply_q ? flags_q.unbalWithin : 1'h1)
            ubActive_q <= 1'h0;
    end

    assign supplyFault = flags_q.underVolt || flags_q.overVolt || ubActive_q || flags_q.thermShut;
    // Only trust a low pin while we are not pulling it ourselves
    assign extLow = !faultIndicatorPinIn && !faultIndicatorPinOe;
    assign active = state_q == ST_MUTE || state_q == ST_OPERATE;

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb
    begin
        state_d = state_q;
        causeSet = '0;
        case (state_q)
            ST_SLEEP:
            begin
                if (wake_q)
                    state_d = symSupply_q ? ST_RAILCHK : ST_CHARGE;
            end
            ST_CHARGE:
            begin
                if (!wake_q)
                    state_d = ST_SLEEP;
                else if (flags_q.refCharged)
                    state_d = ST_RAILCHK;
            end
            ST_RAILCHK:
            begin
                if (!wake_q)
                    state_d = ST_SLEEP;
                else if (flags_q.railShort)
                    causeSet[CAUSE_WP] = 1'h1;
                else
                    state_d = engage_q ? ST_OPERATE : ST_MUTE;
            end
            ST_MUTE, ST_OPERATE:
            begin
                causeSet[CAUSE_OTP] = flags_q.thermShut;
                causeSet[CAUSE_UVP] = flags_q.underVolt;
                causeSet[CAUSE_OVP] = flags_q.overVolt;
                causeSet[CAUSE_UBP] = ubActive_q;
                if (!wake_q)
                    state_d = ST_SLEEP;
                else if (extLow)
                begin
                    state_d = ST_EXT;
                    causeSet[CAUSE_EXT] = 1'h1;
                end
                else if (supplyFault)
                    state_d = ST_HOLD;
                else if (flags_q.loadShort || flags_q.railShort)
                begin
                    state_d = ST_RETRY;
                    causeSet[CAUSE_OCP] = 1'h1;
                end
                else
                    state_d = engage_q ? ST_OPERATE : ST_MUTE;
            end
            ST_RETRY:
            begin
                if (retryDone)
                    state_d = ST_RAILCHK;
            end
            ST_HOLD:
            begin
                if (!supplyFault)
                    state_d = ST_RESTART;
            end
            ST_RESTART:
            begin
                if (supplyFault)
                    state_d = ST_HOLD;
                else if (retryDone)
                    state_d = ST_RAILCHK;
            end
            ST_EXT:
            begin
                if (faultIndicatorPinIn)
                    state_d = wake_q ? ST_RAILCHK : ST_SLEEP;
            end
            default:
            begin
                state_d = ST_SLEEP;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            state_q <= ST_SLEEP;
        else
            state_q <= state_d;
    end

    // ****************************************
    // Stage controls
    // ****************************************
    always_comb
    begin
        stage_d = '0;
        stage_d.powerStage = state_d == ST_MUTE || state_d == ST_OPERATE;
        stage_d.inputConv = state_d == ST_OPERATE;
        stage_d.idleSwitch = state_d == ST_MUTE;
        stage_d.currentClamp = stage_d.powerStage && flags_q.currentLimit;
        // Buffers only make sense with a single-ended supply
        stage_d.halfRailBufferOne = !symSupply_q && wake_q && state_d != ST_SLEEP;
        stage_d.halfRailBufferTwo = stage_d.halfRailBufferOne;
        stage_d.halfRailReference = wake_q && state_d != ST_SLEEP;
    end

    // Fold-back does not count as a protection for the pin
    assign diagLow = state_d == ST_HOLD
        || (state_d == ST_RETRY && (timerRestart || msCnt_q < MS_W'(FAULT_INDICATOR_PIN_LOW_MS)))
        || (state_d == ST_RAILCHK && flags_q.railShort);

    always_ff @(posedge clock)
    begin
        if (srst)
            {stageCtrl, faultIndicatorPinOe} <= '0;
        else
            {stageCtrl, faultIndicatorPinOe} <= {stage_d, diagLow};
    end

    assign faultIndicatorPinOut = 1'h0;

    always_ff @(posedge clock)
    begin
        if (srst || !active)
            gainAtten <= '0;
        else if (tick && flags_q.thermFold && gainAtten != GAIN_W'(GAIN_STEPS))
            gainAtten <= gainAtten + 1'h1;
        else if (tick && !flags_q.thermFold && gainAtten != '0)
            gainAtten <= gainAtten - 1'h1;
    end

    // ****************************************
    // APB slave
    // ****************************************
    logic access, mapped;
    assign access = psel && penable && !pready;
    assign mapped = paddr == CTRL_ADDR || paddr == STATUS_ADDR || paddr == CAUSE_ADDR;

    always_ff @(posedge clock)
    begin
        if (srst)
            {pready, pslverr, prdata} <= '0;
        else
        begin
            pready <= access;
            pslverr <= access && !mapped;
            prdata <= '0;
            if (access && !pwrite)
            begin
                case (paddr)
                    CTRL_ADDR: prdata[CTRL_SYM_BIT] <= symSupply_q;
                    STATUS_ADDR:
                    begin
                        prdata[STATUS_STATE_LSB +: 4] <= state_q;
                        prdata[STATUS_GAIN_LSB +: GAIN_W] <= gainAtten;
                        prdata[STATUS_PIN_BIT] <= faultIndicatorPinIn;
                        prdata[STATUS_UB_BIT] <= ubActive_q;
                    end
                    CAUSE_ADDR: prdata[CAUSE_W-1:0] <= cause_q;
                    default: prdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            symSupply_q <= CTRL_SYM_RESET;
        else if (access && pwrite && paddr == CTRL_ADDR)
            symSupply_q <= pwdata[CTRL_SYM_BIT];
    end

    // Set beats write-one-to-clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (srst)
            cause_q <= '0;
        else if (access && pwrite && paddr == CAUSE_ADDR)
            cause_q <= (cause_q & ~pwdata[CAUSE_W-1:0]) | causeSet;
        else
            cause_q <= cause_q | causeSet;
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence shortSeen;
        active && !extLow && wake_q && !supplyFault && flags_q.loadShort;
    endsequence

    sequence offThenRetry;
        !stageCtrl.powerStage && state_q == ST_RETRY;
    endsequence

    otp_shutdown_a: assert property (active && wake_q && !extLow && flags_q.thermShut |=>
        !stageCtrl.powerStage && state_q == ST_HOLD) else $error("overtemperature did not stop the stage");
    current_clamp_a: assert property (active && wake_q && !extLow && !supplyFault && !flags_q.loadShort &&
        !flags_q.railShort && flags_q.currentLimit |=> stageCtrl.currentClamp) else $error("current clamp missing");
    ocp_off_a: assert property (shortSeen |=> offThenRetry ##1 offThenRetry)
        else $error("stage not held off after short");
    fault_indicator_pin_window_a: assert property (state_q == ST_RETRY && msCnt_q < MS_W'(FAULT_INDICATOR_PIN_LOW_MS - 1)
        |=> faultIndicatorPinOe) else $error("diagnostic released too early");
    fault_indicator_pin_release_a: assert property (state_q == ST_RETRY && state_d == ST_RETRY &&
        msCnt_q >= MS_W'(FAULT_INDICATOR_PIN_LOW_MS) |=> !faultIndicatorPinOe) else $error("diagnostic held past window");
    retry_path_a: assert property (state_q == ST_RETRY && retryDone |=> state_q == ST_RAILCHK)
        else $error("retry did not run rail check");
    rail_halt_a: assert property (state_q == ST_RAILCHK && wake_q && flags_q.railShort
        |=> !stageCtrl.powerStage && faultIndicatorPinOe) else $error("start-up passed a rail short");
    start_check_a: assert property ($rose(stageCtrl.powerStage) |-> $past(state_q) == ST_RAILCHK)
        else $error("stage enabled without rail check");
    uvp_off_a: assert property (active && wake_q && !extLow && flags_q.underVolt
        |=> !stageCtrl.powerStage ##1 !stageCtrl.powerStage) else $error("undervoltage did not shut down");
    sym_buffers_a: assert property (symSupply_q |=> !stageCtrl.halfRailBufferOne
        && !stageCtrl.halfRailBufferTwo) else $error("half-rail buffers on with symmetric supply");
    sleep_mode_a: assert property (active && !wake_q |=> state_q == ST_SLEEP
        && !stageCtrl.powerStage) else $error("wake low did not select sleep");
    mute_mode_a: assert property (state_q == ST_MUTE |-> stageCtrl.idleSwitch
        && !stageCtrl.inputConv) else $error("mute output not idle");
    ext_fault_a: assert property (active && wake_q && extLow |=> state_q == ST_EXT
        && !stageCtrl.powerStage) else $error("external fault ignored");

endmodule

// >>> amp_protection_pkg.sv
package amp_protection_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLOCK_KHZ = 125000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = TICK_MS * CLOCK_KHZ;
    localparam int RETRY_MS = 100;
    localparam int FAULT_INDICATOR_PIN_LOW_MS = 50;
    localparam int GAIN_STEPS = 15;
    localparam int GAIN_W = 4;
    localparam int MS_W = 7;
    localparam int TICK_W = 17;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] CAUSE_ADDR = 8'h08;
    localparam int CTRL_SYM_BIT = 0;
    localparam logic CTRL_SYM_RESET = 1'h0;
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_GAIN_LSB = 4;
    localparam int STATUS_PIN_BIT = 8;
    localparam int STATUS_UB_BIT = 9;
    localparam int CAUSE_OTP = 0;
    localparam int CAUSE_OCP = 1;
    localparam int CAUSE_WP = 2;
    localparam int CAUSE_UVP = 3;
    localparam int CAUSE_OVP = 4;
    localparam int CAUSE_UBP = 5;
    localparam int CAUSE_EXT = 6;
    localparam int CAUSE_W = 7;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic thermFold;
        logic thermShut;
        logic currentLimit;
        logic loadShort;
        logic railShort;
        logic underVolt;
        logic overVolt;
        logic unbalLow;
        logic unbalHigh;
        logic unbalWithin;
        logic refCharged;
    } protFlags_t;

    typedef struct packed {
        logic powerStage;
        logic inputConv;
        logic idleSwitch;
        logic currentClamp;
        logic halfRailBufferOne;
        logic halfRailBufferTwo;
        logic halfRailReference;
    } stageCtrl_t;

    typedef enum logic [3:0] {
        ST_SLEEP, ST_CHARGE, ST_RAILCHK, ST_MUTE, ST_OPERATE,
        ST_RETRY, ST_HOLD, ST_RESTART, ST_EXT
    } ampState_t;

endpackage

// >>> amp_system_controller.sv
`timescale 1ns/1ps
module amp_system_controller
(
    input wire logic clock,
    input wire logic wakeReq,
    input wire logic engageReq,
    input wire logic pullReq,
    input wire logic devOe,
    input wire logic devOut,
    output logic wakeSelectInput,
    output logic engageInput,
    output logic pinLevel
);
    logic pull_q;

    initial
    begin
        pull_q = 1'h0;
    end

    // ****************************************
    // Mode pins and diagnostic wire
    // ****************************************
    assign wakeSelectInput = wakeReq;
    assign engageInput = engageReq & wakeReq;
    always @(posedge clock)
    begin
        pull_q <= pullReq;
    end
    // Pull-up keeps the wire high unless either side sinks it
    assign pinLevel = (devOe ? devOut : 1'h1) & !pull_q;
endmodule

// >>> tb_amp_protection_manager.sv
`timescale 1ns/1ps
module tb_amp_protection_manager;
    import amp_protection_pkg::*;
    // Short tick keeps 100 ms waits near a thousand cycles
    localparam int T = 10;
    logic clock = 1'h0;
    logic srst = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, pinOut, pinOe, pinLevel, wake, engage;
    logic wakeReq = 1'h0, engageReq = 1'h0, pullReq = 1'h0;
    protFlags_t flags = '0;
    stageCtrl_t stage;
    logic [GAIN_W-1:0] gain;
    int badCount = 0, checked = 0, cycles = 0;

    amp_protection_manager #(.TICK_COUNT(T)) u_dut (.clock(clock), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wakeSelectInput(wake), .engageInput(engage),
        .protFlags(flags), .faultIndicatorPinIn(pinLevel), .faultIndicatorPinOut(pinOut),
        .faultIndicatorPinOe(pinOe), .stageCtrl(stage), .gainAtten(gain));
    amp_system_controller u_ctrl (.clock(clock), .wakeReq(wakeReq), .engageReq(engageReq),
        .pullReq(pullReq), .devOe(pinOe), .devOut(pinOut), .wakeSelectInput(wake),
        .engageInput(engage), .pinLevel(pinLevel));

    // ****************************************
    // Helpers
    // ****************************************
    initial
    begin
        forever #4 clock = ~clock;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            badCount++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            badCount++;
            $display("[ERR] %0t %s: got %0h want %0h", $time, what, seen, exp);
        end
    endtask

    // Entered just after a rising edge; request held until pready is sampled
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // Let an edge pass so a following call never reassigns psel in this step
        @(posedge clock);
        check(n < 20, 1, "apb hang");
    endtask

    task automatic st(input logic [3:0] s);
        logic [31:0] q;
        logic e;
        apb(1'h0, STATUS_ADDR, 32'h0, q, e);
        check(q[3:0], s, "state");
    endtask

    function automatic logic sig(input int sel);
        return sel == 0 ? stage.powerStage : pinOe;
    endfunction

    // Bounded wait; the edge count must fall inside the window
    task automatic waitFor(input int sel, input logic val, input int lo, input int hi, input string what);
        int n;
        n = 0;
        while (sig(sel) !== val && n <= hi)
        begin
            @(posedge clock);
            n++;
        end
        check(n >= lo && n <= hi, 1, what);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        logic [31:0] q;
        logic e;
        check(stage, 0, "stage at reset");
        apb(1'h0, CTRL_ADDR, 32'h0, q, e);
        check(q, 0, "ctrl reset");
        apb(1'h1, 8'h0C, 32'hFFFFFFFF, q, e);
        check(e, 1, "unmapped err");
        apb(1'h0, 8'h0C, 32'h0, q, e);
        check(e, 1, "unmapped read err");
        check(q, 0, "unmapped read data");
        apb(1'h1, CTRL_ADDR, 32'h1, q, e);
        apb(1'h0, CTRL_ADDR, 32'h0, q, e);
        check(q, 1, "ctrl write");
        st(ST_SLEEP);
        $display("reset done");
    endtask

    task automatic t_startup;
        flags.railShort <= 1'h1;
        wakeReq <= 1'h1;
        repeat (5) @(posedge clock);
        st(ST_RAILCHK);
        check({stage.powerStage, pinOe, pinOut}, 3'h2, "halt on rail short");
        flags.railShort <= 1'h0;
        waitFor(0, 1'h1, 1, 8, "start");
        check({stage.idleSwitch, stage.inputConv}, 2'h2, "mute");
        check({stage.halfRailBufferOne, stage.halfRailBufferTwo}, 2'h0, "sym buffers");
        engageReq <= 1'h1;
        repeat (4) @(posedge clock);
        check(stage.inputConv, 1, "operate");
        st(ST_OPERATE);
        flags.thermFold <= 1'h1;
        repeat (20 * T) @(posedge clock);
        check({gain, stage.powerStage, pinOe}, 6'h3E, "foldback");
        flags.thermFold <= 1'h0;
        flags.currentLimit <= 1'h1;
        repeat (4) @(posedge clock);
        check({stage.currentClamp, stage.powerStage, pinOe}, 3'h6, "clamp");
        flags.currentLimit <= 1'h0;
        $display("startup done");
    endtask

    task automatic t_shorts;
        flags.loadShort <= 1'h1;
        waitFor(0, 1'h0, 0, 4, "short off");
        check(pinOe, 1, "pin low");
        waitFor(1, 1'h0, 49 * T, 51 * T + 4, "pin release");
        waitFor(0, 1'h1, 48 * T, 51 * T + 8, "retry");
        waitFor(0, 1'h0, 0, 4, "short again");
        flags.loadShort <= 1'h0;
        waitFor(0, 1'h1, 99 * T, 101 * T + 8, "second retry");
        flags.railShort <= 1'h1;
        waitFor(0, 1'h0, 0, 4, "rail off");
        repeat (300 * T) @(posedge clock);
        check(stage.powerStage, 0, "no rail retry");
        st(ST_RAILCHK);
        flags.railShort <= 1'h0;
        waitFor(0, 1'h1, 0, 8, "rail gone");
        $display("shorts done");
    endtask

    task automatic t_supply;
        protFlags_t m;
        int bits[5] = '{CAUSE_OTP, CAUSE_UVP, CAUSE_OVP, CAUSE_UBP, CAUSE_UBP};
        logic [31:0] q;
        logic e;
        for (int i = 0; i < 5; i++)
        begin
            m = '0;
            m.thermShut = (i == 0);
            m.underVolt = (i == 1);
            m.overVolt = (i == 2);
            m.unbalLow = (i == 3);
            m.unbalHigh = (i == 4);
            flags <= flags | m;
            waitFor(0, 1'h0, 0, i > 2 ? 4 : 3, "fault off");
            check(pinOe, 1, "fault pin");
            flags <= flags & ~m;
            if (i > 2)
            begin
                repeat (20 * T) @(posedge clock);
                check(stage.powerStage, 0, "unbal held");
                flags.unbalWithin <= 1'h1;
            end
            waitFor(0, 1'h1, 99 * T, 101 * T + 8, "fault restart");
            flags.unbalWithin <= 1'h0;
            apb(1'h0, CAUSE_ADDR, 32'h0, q, e);
            check(q[bits[i]], 1, "cause set");
            apb(1'h1, CAUSE_ADDR, 32'h1 << bits[i], q, e);
            apb(1'h0, CAUSE_ADDR, 32'h0, q, e);
            check(q[bits[i]], 0, "cause clear");
        end
        $display("supply done");
    endtask

    task automatic t_ext;
        pullReq <= 1'h1;
        waitFor(0, 1'h0, 0, 5, "ext off");
        st(ST_EXT);
        pullReq <= 1'h0;
        waitFor(0, 1'h1, 0, 10, "ext release");
        $display("ext done");
    endtask

    task automatic t_asym;
        logic [31:0] q;
        logic e;
        wakeReq <= 1'h0;
        engageReq <= 1'h0;
        waitFor(0, 1'h0, 0, 4, "sleep");
        st(ST_SLEEP);
        apb(1'h1, CTRL_ADDR, 32'h0, q, e);
        wakeReq <= 1'h1;
        repeat (5) @(posedge clock);
        st(ST_CHARGE);
        check({stage.halfRailBufferOne, stage.halfRailBufferTwo, stage.powerStage}, 3'h6, "charge");
        check(stage.halfRailReference, 1, "reference on");
        flags.refCharged <= 1'h1;
        waitFor(0, 1'h1, 0, 10, "charged");
        check(stage.idleSwitch, 1, "asym mute");
        $display("asym done");
    endtask

    initial
    begin
        repeat (5) @(posedge clock);
        srst <= 1'h0;
        @(posedge clock);
        t_reset();
        t_startup();
        t_shorts();
        t_supply();
        t_ext();
        t_asym();
        report_and_stop();
    end
endmodule
